/* hw/sleep_ctrl.sv */
// Purpose: sleep-mode clock gating and per-module clock stop
// Assumes: single 20 MHz clock, synchronous active-high reset
// Notes:   external level lines are synchronised with three flops
`timescale 1ns/10ps
`include "sleep_ctrl_cfg.svh"

module sleep_ctrl
    import sleep_ctrl_pkg::*;
#(
    parameter int STARTUP_CYC = `STARTUP_CYC_DEF
) (
    // clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    // low-power control from the core
    input  wire logic                    i_sleep_enable_bit,
    input  wire logic [2:0]              i_low_power_mode_select,
    input  wire logic                    i_sleep_instr,
    input  wire logic                    i_ext_crystal_sel,
    input  wire logic                    i_conv_enabled,
    input  wire logic                    i_atimer_async,
    input  wire logic                    i_atimer_sync,
    input  wire logic                    i_atimer_enabled,
    // wake-up sources
    input  wire wake_src_s               i_wake,
    input  wire logic                    i_ext_irq_line_0,
    input  wire logic                    i_ext_irq_line_1,
    // per-module clock stop
    input  wire logic [`CSTOP_BITS-1:0]  i_module_clock_stop_reg,
    input  wire logic [`CSTOP_BITS-1:0]  i_periph_access,
    // outputs
    output logic                         o_sleeping,
    output clk_gates_s                   o_gates,
    output logic [`CSTOP_BITS-1:0]       o_periph_clk_en,
    output logic [`CSTOP_BITS-1:0]       o_periph_access_ok,
    output logic                         o_conv_start,
    output logic                         o_core_hold,
    output logic                         o_resume_irq,
    output logic                         o_resume_vector,
    output logic                         o_nop_instr
);

    localparam int LVL_CYC = `LEVEL_HOLD_CYC;

    typedef struct packed {
        pm_state_e                state;
        logic [2:0]               mode;
        logic [15:0]              cnt;
        logic [3:0]               lvl_cnt;
        logic [2:0]               sync0;
        logic [2:0]               sync1;
        logic [1:0]               ext_lvl;
        logic                     by_reset;
        clk_gates_s               gates;
        logic [`CSTOP_BITS-1:0]   pclk;
        logic                     conv_start;
        logic                     resume_irq;
        logic                     resume_vec;
        logic                     nop;
    } pm_s;

    pm_s r;
    pm_s next_r;

    logic lvl0;
    logic lvl1;
    logic lvl_held;
    logic wake_ok;
    logic valid_mode;

    // ------------------------------------------------------------
    // wake qualification
    // ------------------------------------------------------------
    // a line change counts once the last two flops agree
    assign lvl0     = (r.sync0[2] == r.sync0[1]) ? r.sync0[1] : r.ext_lvl[0];
    assign lvl1     = (r.sync1[2] == r.sync1[1]) ? r.sync1[1] : r.ext_lvl[1];
    assign lvl_held = ({12'h000, r.lvl_cnt} >= 16'(LVL_CYC));

    always_comb begin
        wake_ok = 1'b0;
        case (r.mode)
            `MODE_IDLE: begin
                wake_ok = (|i_wake) | lvl0 | lvl1;
            end
            `MODE_NOISE_RED: begin
                wake_ok = i_wake.conv_done | i_wake.twi_match | i_wake.atimer_irq
                        | i_wake.spm_ready | i_wake.pin_change | i_wake.ext_level_0
                        | i_wake.ext_level_1 | lvl_held;
            end
            `MODE_POWER_SAVE: begin
                wake_ok = i_wake.twi_match | i_wake.pin_change | lvl_held
                        | (i_atimer_enabled & i_wake.atimer_irq);
            end
            default: begin
                wake_ok = i_wake.twi_match | i_wake.pin_change | lvl_held;
            end
        endcase
        wake_ok = wake_ok | i_wake.wdt_event;
    end

    assign valid_mode = (i_low_power_mode_select == `MODE_IDLE)
                      | (i_low_power_mode_select == `MODE_NOISE_RED)
                      | (i_low_power_mode_select == `MODE_POWER_DOWN)
                      | (i_low_power_mode_select == `MODE_POWER_SAVE)
                      | ((i_low_power_mode_select == `MODE_STANDBY) & i_ext_crystal_sel);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r            = r;
        next_r.sync0      = {r.sync0[1:0], i_ext_irq_line_0};
        next_r.sync1      = {r.sync1[1:0], i_ext_irq_line_1};
        next_r.ext_lvl    = {lvl1, lvl0};
        next_r.conv_start = 1'b0;
        next_r.resume_irq = 1'b0;
        next_r.resume_vec = 1'b0;
        next_r.nop        = 1'b0;
        if (lvl0 | lvl1) begin
            if (r.lvl_cnt != 4'hf) begin
                next_r.lvl_cnt = r.lvl_cnt + 4'h1;
            end
        end else begin
            next_r.lvl_cnt = 4'h0;
        end
        case (r.state)
            ST_RUN: begin
                if (i_sleep_instr & ~i_sleep_enable_bit) begin
                    next_r.nop = 1'b1;
                end else if (i_sleep_instr & i_sleep_enable_bit & valid_mode) begin
                    next_r.state      = ST_SLEEP;
                    next_r.mode       = i_low_power_mode_select;
                    next_r.conv_start = i_conv_enabled
                        & ((i_low_power_mode_select == `MODE_IDLE)
                        | (i_low_power_mode_select == `MODE_NOISE_RED));
                end
            end
            ST_SLEEP: begin
                if (i_wake.ext_reset | i_wake.brown_out | i_wake.wdt_event
                    | wake_ok) begin
                    next_r.by_reset = i_wake.ext_reset | i_wake.brown_out;
                    if ((r.mode == `MODE_POWER_DOWN) | (r.mode == `MODE_POWER_SAVE)) begin
                        next_r.cnt = 16'(STARTUP_CYC);
                    end else if (r.mode == `MODE_STANDBY) begin
                        next_r.cnt = {12'h000, `STANDBY_WAKE_CYC} - 16'h1;
                    end else begin
                        next_r.cnt = 16'h0;
                    end
                    next_r.state = ST_START;
                end
            end
            ST_START: begin
                if (r.cnt == 16'h0) begin
                    next_r.state = ST_HOLD;
                    next_r.cnt   = {12'h000, `WAKE_HOLD_CYC} - 16'h1;
                end else begin
                    next_r.cnt = r.cnt - 16'h1;
                end
            end
            default: begin
                if (r.cnt == 16'h0) begin
                    next_r.state      = ST_RUN;
                    next_r.resume_vec = r.by_reset;
                    next_r.resume_irq = ~r.by_reset;
                    next_r.by_reset   = 1'b0;
                end else begin
                    next_r.cnt = r.cnt - 16'h1;
                end
            end
        endcase

        // clock domain gates; run everything unless asleep
        next_r.gates = '{core: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1,
                         async: 1'b1, main_osc: 1'b1, timer_osc: 1'b1};
        if (next_r.state == ST_SLEEP) begin
            next_r.gates.core  = 1'b0;
            next_r.gates.flash = 1'b0;
            case (next_r.mode)
                `MODE_IDLE: begin
                    next_r.gates.timer_osc = i_atimer_async;
                end
                `MODE_NOISE_RED: begin
                    next_r.gates.io        = 1'b0;
                    next_r.gates.timer_osc = i_atimer_async;
                end
                `MODE_POWER_SAVE: begin
                    next_r.gates.io        = 1'b0;
                    next_r.gates.conv      = 1'b0;
                    next_r.gates.async     = i_atimer_enabled;
                    next_r.gates.timer_osc = i_atimer_enabled & i_atimer_async;
                    next_r.gates.main_osc  = i_atimer_enabled & i_atimer_sync;
                end
                `MODE_STANDBY: begin
                    next_r.gates.io        = 1'b0;
                    next_r.gates.conv      = 1'b0;
                    next_r.gates.async     = 1'b0;
                    next_r.gates.timer_osc = 1'b0;
                end
                default: begin
                    next_r.gates.io        = 1'b0;
                    next_r.gates.conv      = 1'b0;
                    next_r.gates.async     = 1'b0;
                    next_r.gates.main_osc  = 1'b0;
                    next_r.gates.timer_osc = 1'b0;
                end
            endcase
        end

        // per-module clocks follow the io clock and their stop bit
        next_r.pclk = ~i_module_clock_stop_reg & {`CSTOP_BITS{next_r.gates.io}};
    end

    // ------------------------------------------------------------
    // state register; all of r resets, with every gate and module clock on
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r          <= '0;
            r.state    <= ST_RUN;
            r.gates    <= 7'h7f;
            r.pclk     <= ~`CSTOP_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign o_sleeping         = (r.state == ST_SLEEP);
    assign o_gates            = r.gates;
    assign o_periph_clk_en    = r.pclk;
    assign o_periph_access_ok = i_periph_access & ~i_module_clock_stop_reg;
    assign o_conv_start       = r.conv_start;
    assign o_core_hold        = (r.state != ST_RUN);
    assign o_resume_irq       = r.resume_irq;
    assign o_resume_vector    = r.resume_vec;
    assign o_nop_instr        = r.nop;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sleep_needs_enable: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state == ST_RUN && next_r.state == ST_SLEEP) |-> i_sleep_enable_bit && i_sleep_instr)
        else $error("sleep entered without enable");
    a_nop_keeps_run: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state == ST_RUN && i_sleep_instr && !i_sleep_enable_bit) |=> o_nop_instr && r.gates.core)
        else $error("sleep without enable not a nop");
    a_idle_gates_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_IDLE) |-> !r.gates.core && !r.gates.flash && r.gates.io && r.gates.conv)
        else $error("idle gating wrong");
    a_noise_gates_ok: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_NOISE_RED) |-> !r.gates.io && r.gates.conv && r.gates.async)
        else $error("noise reduction gating wrong");
    a_pdown_gates_off: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_POWER_DOWN) |-> r.gates == 7'h00)
        else $error("power-down left a clock on");
    a_conv_on_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state == ST_RUN && i_sleep_instr && i_sleep_enable_bit && valid_mode && i_conv_enabled
         && i_low_power_mode_select == `MODE_IDLE) |=> o_conv_start)
        else $error("no conversion on idle entry");
    a_hold_four_cyc: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state == ST_START && next_r.state == ST_HOLD) |=> o_core_hold [*4] ##1 !o_core_hold)
        else $error("core hold not four cycles");
    a_standby_six: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_STANDBY && next_r.state == ST_START) |=> ##6 r.state == ST_HOLD)
        else $error("standby wake not six cycles");
    a_stop_blocks_io: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_module_clock_stop_reg[0]) |-> !o_periph_access_ok[0] ##1 !o_periph_clk_en[0])
        else $error("stopped module still reachable");
    a_idle_osc_on: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_IDLE) |-> r.gates.main_osc && r.gates.async)
        else $error("idle stopped an oscillator");
    a_psave_timer_run: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_POWER_SAVE) |-> r.gates.async == $past(i_atimer_enabled)
            && !r.gates.io && !r.gates.core)
        else $error("power-save timer clock wrong");
    a_psave_osc_src: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_POWER_SAVE)
            |-> r.gates.main_osc == ($past(i_atimer_enabled) && $past(i_atimer_sync)))
        else $error("power-save main clock wrong");
    a_standby_osc_on: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_STANDBY) |-> r.gates.main_osc && !r.gates.io && !r.gates.async)
        else $error("standby oscillator wrong");
    a_conv_only_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        o_conv_start |-> o_sleeping && (r.mode == `MODE_IDLE || r.mode == `MODE_NOISE_RED))
        else $error("conversion start outside entry");
    a_nop_no_sleep: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state == ST_RUN && i_sleep_instr && !i_sleep_enable_bit) |=> !o_sleeping && r.gates == 7'h7f)
        else $error("nop stopped a clock");

    // ------------------------------------------------------------
    // assertions: wake-up and start-up
    // ------------------------------------------------------------
    a_idle_any_wake: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_IDLE && i_wake != 11'h000) |=> r.state == ST_START)
        else $error("idle ignored a wake source");
    a_noise_ignores: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_NOISE_RED && (i_wake & 11'h3ff) == 11'h000 && !lvl_held)
            |=> o_sleeping)
        else $error("noise reduction woke on a foreign source");
    a_pdown_wake_set: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_POWER_DOWN && (i_wake & 11'h1e1) == 11'h000 && !lvl_held)
            |=> o_sleeping)
        else $error("power-down woke on a foreign source");
    a_level_wakes: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode == `MODE_POWER_DOWN && lvl_held) |=> r.state == ST_START)
        else $error("held level did not wake");
    a_startup_load: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && (r.mode == `MODE_POWER_DOWN || r.mode == `MODE_POWER_SAVE) && next_r.state == ST_START)
            |=> r.cnt == 16'(STARTUP_CYC))
        else $error("start-up wait not loaded");
    a_reset_marks: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && (i_wake.ext_reset || i_wake.brown_out)) |=> r.state == ST_START && r.by_reset)
        else $error("reset wake not marked");
    a_vector_alone: assert property (@(posedge i_clk) disable iff (i_rst)
        o_resume_vector |-> r.state == ST_RUN && !o_resume_irq)
        else $error("vector resume with irq resume");
    a_irq_resume_run: assert property (@(posedge i_clk) disable iff (i_rst)
        o_resume_irq |-> !o_core_hold && !o_resume_vector)
        else $error("irq resume while held");

    // ------------------------------------------------------------
    // assertions: per-module clocks
    // ------------------------------------------------------------
    a_pclk_sleep_off: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sleeping && r.mode != `MODE_IDLE) |-> o_periph_clk_en == '0)
        else $error("module clock runs in deep sleep");
    a_pclk_restart: assert property (@(posedge i_clk) disable iff (i_rst)
        (r.state != ST_SLEEP && !i_sleep_instr && !i_module_clock_stop_reg[0]) |=> o_periph_clk_en[0])
        else $error("cleared module clock not restarted");
    a_access_gated: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_module_clock_stop_reg != '0) |-> (o_periph_access_ok & i_module_clock_stop_reg) == '0)
        else $error("stopped module access granted");

endmodule

/* hw/sleep_ctrl_cfg.svh */
// Purpose: constants for the sleep-mode clock gating controller
// Assumes: 20 MHz system clock
// Notes:   mode codes, timing counts and clock-stop bits
`ifndef SLEEP_CTRL_CFG_SVH
`define SLEEP_CTRL_CFG_SVH

`define MODE_IDLE        3'h0
`define MODE_NOISE_RED   3'h1
`define MODE_POWER_DOWN  3'h2
`define MODE_POWER_SAVE  3'h3
`define MODE_STANDBY     3'h6
`define WAKE_HOLD_CYC    4'h4
`define STANDBY_WAKE_CYC 4'h6
`define CLK_MHZ          20
`define LEVEL_HOLD_NS    250
`define LEVEL_HOLD_CYC   (((`LEVEL_HOLD_NS * `CLK_MHZ) + 999) / 1000)
`define STARTUP_CYC_DEF  16
`define CSTOP_BITS       8
`define CSTOP_RESET      8'h00

`endif

/* hw/sleep_ctrl_pkg.sv */
// Purpose: types for the sleep-mode clock gating controller
// Assumes: constants come from sleep_ctrl_cfg.svh
// Notes:   state and carrier structs
package sleep_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_SLEEP  = 3'b001,
        ST_START  = 3'b010,
        ST_HOLD   = 3'b011
    } pm_state_e;

    // gated clock enables towards the clock domains
    typedef struct packed {
        logic core;
        logic flash;
        logic io;
        logic conv;
        logic async;
        logic main_osc;
        logic timer_osc;
    } clk_gates_s;

    // wake-up sources, levels or pulses from the interrupt system
    typedef struct packed {
        logic any_irq;
        logic conv_done;
        logic ext_reset;
        logic wdt_event;
        logic brown_out;
        logic twi_match;
        logic atimer_irq;
        logic spm_ready;
        logic ext_level_0;
        logic ext_level_1;
        logic pin_change;
    } wake_src_s;

endpackage

/* bench/wake_partner.sv */
// Purpose: model of the interrupt system and wake-up sources
// Assumes: sources and pins change at the falling edge of i_clk
// Notes:   a raised source stays up until the bench drops it
`timescale 1ns/10ps
module wake_partner
    import sleep_ctrl_pkg::*;
(
    // clock
    input  wire logic i_clk,
    // wake-up sources
    output wake_src_s o_wake,
    output logic      o_ext_irq_line_0,
    output logic      o_ext_irq_line_1
);
    initial begin
        o_wake = '0;
        o_ext_irq_line_0 = 1'b0;
        o_ext_irq_line_1 = 1'b0;
    end

    // a source is a level held until drop(), not a pulse
    task automatic raise(input int idx);
        @(negedge i_clk);
        o_wake[idx] = 1'b1;
    endtask

    task automatic drop();
        @(negedge i_clk);
        o_wake = '0;
    endtask

    // external level lines, high is the active level
    task automatic ext_line(input int line, input logic v);
        @(negedge i_clk);
        if (line == 0) begin
            o_ext_irq_line_0 = v;
        end else begin
            o_ext_irq_line_1 = v;
        end
    endtask
endmodule

/* bench/tb_sleep_ctrl.sv */
// Purpose: self-checking bench for the sleep-mode clock gating controller
// Assumes: short start-up count of 4 cycles, inputs driven at the falling edge
// Notes:   wake counts run from the edge that first sees the source
`timescale 1ns/10ps
module tb_sleep_ctrl
    import sleep_ctrl_pkg::*;
;
    localparam int SU = 4;
    localparam int W_ANY = 10, W_CONV = 9, W_RST = 8, W_TWI = 5, W_ATIM = 4, W_PIN = 0;

    logic       i_clk = 1'b0, i_rst = 1'b1, en = 1'b0, instr = 1'b0, xtal = 1'b0, conv_en = 1'b1;
    logic       a_async = 1'b1, a_sync = 1'b0, a_en = 1'b1;
    logic [2:0] mode = 3'h0;
    logic [7:0] stop = 8'h00, access = 8'hff, clk_en, acc_ok;
    logic       sleeping, conv_start, core_hold, res_irq, res_vec, nop;
    logic       ext0, ext1;
    clk_gates_s gates;
    wake_src_s  wake;
    int         bad_count = 0, samples_checked = 0, n;

    always #25 i_clk = ~i_clk;

    wake_partner P (.i_clk(i_clk), .o_wake(wake), .o_ext_irq_line_0(ext0), .o_ext_irq_line_1(ext1));

    sleep_ctrl #(.STARTUP_CYC(SU)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_sleep_enable_bit(en), .i_low_power_mode_select(mode),
        .i_sleep_instr(instr), .i_ext_crystal_sel(xtal), .i_conv_enabled(conv_en),
        .i_atimer_async(a_async), .i_atimer_sync(a_sync), .i_atimer_enabled(a_en), .i_wake(wake),
        .i_ext_irq_line_0(ext0), .i_ext_irq_line_1(ext1), .i_module_clock_stop_reg(stop),
        .i_periph_access(access), .o_sleeping(sleeping), .o_gates(gates), .o_periph_clk_en(clk_en),
        .o_periph_access_ok(acc_ok), .o_conv_start(conv_start), .o_core_hold(core_hold),
        .o_resume_irq(res_irq), .o_resume_vector(res_vec), .o_nop_instr(nop));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic go(input logic [2:0] m, input logic e);
        @(negedge i_clk);
        mode = m;
        en = e;
        instr = 1'b1;
        @(negedge i_clk);
        instr = 1'b0;
    endtask

    // raise a source and count cycles until either resume pulse
    task automatic wake_up(input int idx, output int cnt);
        P.raise(idx);
        cnt = 0;
        do begin
            @(negedge i_clk);
            cnt++;
        end while ((res_irq | res_vec) !== 1'b1 && cnt < 300);
    endtask

    task automatic no_wake(input int idx);
        P.raise(idx);
        repeat (20) @(negedge i_clk);
        chk("still asleep", 8'h01, {7'h0, sleeping});
        P.drop();
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_nop();
        go(3'h0, 1'b0);
        chk("nop pulse", 8'h01, {7'h0, nop});
        chk("nop gates", 8'h7f, {1'b0, gates});
        chk("nop sleeping", 8'h00, {7'h0, sleeping});
    endtask

    task automatic s_idle();
        go(3'h0, 1'b1);
        chk("idle gates", 8'h1f, {1'b0, gates});
        chk("idle conv start", 8'h01, {7'h0, conv_start});
        chk("idle hold", 8'h01, {7'h0, core_hold});
        stop = 8'ha5;                                              // modules quiesced first
        @(negedge i_clk);
        chk("idle stop clk", 8'h5a, clk_en);
        chk("idle stop access", 8'h5a, acc_ok);
        wake_up(W_TWI, n);
        chk_cnt("idle wake cycles", 6, n);
        chk("idle resume irq", 8'h01, {7'h0, res_irq});
        P.drop();
        chk("idle gates back", 8'h7f, {1'b0, gates});
        chk("frozen clk still", 8'h5a, clk_en);
        stop = 8'h00;
        @(negedge i_clk);
        chk("stop cleared", 8'hff, clk_en);
    endtask

    task automatic s_noise();
        go(3'h1, 1'b1);
        chk("noise gates", 8'h0f, {1'b0, gates});
        chk("noise conv start", 8'h01, {7'h0, conv_start});
        chk("noise clk en", 8'h00, clk_en);
        no_wake(W_ANY);
        wake_up(W_CONV, n);
        chk_cnt("noise wake cycles", 6, n);
        P.drop();
    endtask

    task automatic s_pdown();
        go(3'h2, 1'b1);
        chk("pdown gates", 8'h00, {1'b0, gates});
        no_wake(W_CONV);
        P.ext_line(0, 1'b1);
        P.ext_line(0, 1'b1);
        P.ext_line(0, 1'b0);
        repeat (12) @(negedge i_clk);
        chk("short level ignored", 8'h01, {7'h0, sleeping});
        wake_up(W_TWI, n);
        chk_cnt("pdown wake cycles", SU + 6, n);
        P.drop();
        go(3'h2, 1'b1);
        P.ext_line(1, 1'b1);
        wake_up(W_CONV, n);
        chk("level wake irq", 8'h01, {7'h0, res_irq});
        chk_cnt("level wake cycles", SU + 13, n);
        P.drop();
        P.ext_line(1, 1'b0);
        repeat (4) @(negedge i_clk);
    endtask

    task automatic s_psave_standby();
        go(3'h3, 1'b1);
        chk("psave gates", 8'h05, {1'b0, gates});
        wake_up(W_ATIM, n);
        chk_cnt("psave wake cycles", SU + 6, n);
        P.drop();
        xtal = 1'b0;
        go(3'h6, 1'b1);
        chk("standby refused", 8'h00, {7'h0, sleeping});
        xtal = 1'b1;
        go(3'h6, 1'b1);
        chk("standby gates", 8'h02, {1'b0, gates});
        wake_up(W_PIN, n);
        chk_cnt("standby wake cycles", 11, n);
        P.drop();
    endtask

    task automatic s_reset_wake();
        go(3'h2, 1'b1);
        wake_up(W_RST, n);
        chk("reset vector", 8'h01, {7'h0, res_vec});
        chk("no irq resume", 8'h00, {7'h0, res_irq});
        P.drop();
    endtask

    initial begin
        #(50 * 6000);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (20) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        chk("reset gates", 8'h7f, {1'b0, gates});
        chk("reset clk en", 8'hff, clk_en);
        s_nop();
        s_idle();
        s_noise();
        s_pdown();
        s_psave_standby();
        s_reset_wake();
        wrap_up();
    end
endmodule
